// ### design/low_voltage_irq_control.sv
`timescale 1ns/1ns
`default_nettype none
module low_voltage_irq_control #(
   parameter int FLAG_TO_IRQ_CYC = low_voltage_irq_pkg::FLAG_TO_IRQ_CYCLES
) (
   input  wire logic                                      ref_clk,
   input  wire logic                                      reset_n,
   input  wire low_voltage_irq_pkg::reg_req_s             reg_req,
   output logic [low_voltage_irq_pkg::DATA_W-1:0]         reg_rdata,
   input  wire low_voltage_irq_pkg::power_mode_e          power_mode,
   input  wire logic                                      low_supply_reset,
   input  wire logic [low_voltage_irq_pkg::LEVELS-1:0]    below_trip,
   output logic [low_voltage_irq_pkg::LEVEL_W-1:0]        trip_level_select,
   output logic                                           monitor_power,
   output logic                                           bandgap_on,
   input  wire logic                                      ext_irq_pin_a,
   input  wire logic                                      ext_irq_pin_b,
   input  wire low_voltage_irq_pkg::irq_sources_s         sources,
   input  wire logic                                      irq_ack,
   output logic                                           irq_req,
   output logic [low_voltage_irq_pkg::VEC_W-1:0]          irq_vector,
   output logic                                           wake
);
   import low_voltage_irq_pkg::*;

   localparam int CNT_W = $clog2(FLAG_TO_IRQ_CYC + 1);

   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic       cur,
                                     input logic       prev);
      logic rise;
      logic fall;
      rise = cur & ~prev;
      fall = ~cur & prev;
      edge_hit = ((sel == EDGE_RISE) && rise) || ((sel == EDGE_FALL) && fall) ||
                 ((sel == EDGE_BOTH) && (rise || fall));
   endfunction

   function automatic logic [VEC_W-1:0] first_set(input logic [PRIMARY-1:0] v);
      logic [VEC_W-1:0] idx;
      idx = '0;
      for (int i = PRIMARY - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = VEC_W'(i);
         end
      end
      first_set = idx;
   endfunction

   function automatic logic grp_hit(input logic [REG_ADDR_W-1:0] addr,
                                    input int                    g);
      grp_hit = (addr == IDX_GROUP_A + REG_ADDR_W'(g));
   endfunction

   logic                   supply_monitor_on;
   logic                   bandgap_force_on;
   logic [3:0]             edge_select;
   logic                   global_irq_enable;
   logic [PRIMARY-1:0]     prim_flag;
   logic [PRIMARY-1:0]     prim_en;
   logic [GROUPS*4-1:0]    grp_flag;
   logic [GROUPS*4-1:0]    grp_en;
   logic [LEVELS-1:0]      below_s1;
   logic [LEVELS-1:0]      below_s2;
   logic [1:0]             pin_s1;
   logic [1:0]             pin_s2;
   logic [1:0]             pin_prev;
   logic                   low_supply_flag;
   logic [CNT_W-1:0]       lv_cnt;
   logic                   lv_event;
   logic                   monitor_active;
   logic [PRIMARY-1:0]     prim_set;
   logic [GROUPS*4-1:0]    grp_set;
   logic [PRIMARY-1:0]     pending;
   logic                   wr_prim_a;
   logic                   wr_prim_b;
   logic                   wr_prim_c;
   logic [PRIMARY-1:0]     prim_wmask;
   logic [PRIMARY-1:0]     prim_flag_wd;
   logic [PRIMARY-1:0]     prim_en_wd;
   logic [GROUPS*4-1:0]    grp_wmask;
   logic [GROUPS*4-1:0]    grp_flag_wd;
   logic [GROUPS*4-1:0]    grp_en_wd;
   logic [DATA_W-1:0]      next_rdata;
   logic [DATA_W-1:0]      wd;

   assign wd = reg_req.wdata;

   // comparator outputs and pins are asynchronous to ref_clk
   // pin_prev follows the second stage only, never the first
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         below_s1 <= '0;
         below_s2 <= '0;
         pin_s1   <= '0;
         pin_s2   <= '0;
         pin_prev <= '0;
      end else begin
         below_s1 <= below_trip;
         below_s2 <= below_s1;
         pin_s1   <= {ext_irq_pin_b, ext_irq_pin_a};
         pin_s2   <= pin_s1;
         pin_prev <= pin_s2;
      end
   end

   // sleep forces off
   // gate is combinational so the monitor drops with the mode change
   assign monitor_active = supply_monitor_on && (power_mode != MODE_SLEEP);
   assign monitor_power  = monitor_active;
   assign bandgap_on = monitor_active || low_supply_reset || bandgap_force_on;

   // flag from selected level; no filtering, toggles pass through
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         low_supply_flag <= 1'b0;
      end else begin
         low_supply_flag <= monitor_active && below_s2[trip_level_select];
      end
   end

   // request only after delay from flag rise, once per rise
   // counter saturates, so only a dip of the flag restarts the wait
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lv_cnt <= '0;
      end else if (!low_supply_flag) begin
         lv_cnt <= '0;
      end else if (lv_cnt != CNT_W'(FLAG_TO_IRQ_CYC)) begin
         lv_cnt <= lv_cnt + 1'b1;
      end
   end
   assign lv_event = low_supply_flag && (lv_cnt == CNT_W'(FLAG_TO_IRQ_CYC - 1));

   // event sources; low supply event joins group b
   assign grp_set = {2'b00, sources.timer_cpt,
                     lv_event, sources.eeprom, sources.serial, sources.adc,
                     sources.timer_std} & GROUP_MASK;

   // edge detection per pin, field per pin
   assign prim_set[0] = edge_hit(edge_select[EDGE_PIN_A_LSB +: 2], pin_s2[0], pin_prev[0]);
   assign prim_set[1] = edge_hit(edge_select[EDGE_PIN_B_LSB +: 2], pin_s2[1], pin_prev[1]);
   assign prim_set[2] = sources.auto_conv;
   assign prim_set[4:3] = sources.timebase;

   // group flag driven by enabled grouped requests
   generate
      for (genvar g = 0; g < GROUPS; g++) begin : g_group
         assign prim_set[5 + g] = |(grp_flag[g*4 +: 4] & grp_en[g*4 +: 4]);
      end
   endgenerate

   // write decode of the primary registers into per-source vectors
   // bit order equals priority order, so the encoder reads the vector as is
   assign wr_prim_a = reg_req.wr && (reg_req.addr == IDX_PRIM_A);
   assign wr_prim_b = reg_req.wr && (reg_req.addr == IDX_PRIM_B);
   assign wr_prim_c = reg_req.wr && (reg_req.addr == IDX_PRIM_C);
   assign prim_wmask = {wr_prim_c, {4{wr_prim_b}}, {3{wr_prim_a}}};
   assign prim_flag_wd = {wd[4], wd[7:4], wd[6:4]};
   assign prim_en_wd   = {wd[0], wd[3:0], wd[3:1]};

   always_comb begin
      grp_wmask   = '0;
      grp_flag_wd = '0;
      grp_en_wd   = '0;
      for (int g = 0; g < GROUPS; g++) begin
         grp_flag_wd[g*4 +: 4] = wd[GROUP_FLAG_LSB +: 4];
         grp_en_wd[g*4 +: 4]   = wd[GROUP_EN_LSB +: 4];
         if (reg_req.wr && grp_hit(reg_req.addr, g)) begin
            grp_wmask[g*4 +: 4] = 4'hF;
         end
      end
      grp_wmask = grp_wmask & GROUP_MASK;
   end

   // events set flags regardless of enable; set beats a write of zero
   // a write of one sets a flag, which lets software preset it
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prim_flag <= '0;
         grp_flag  <= '0;
      end else begin
         prim_flag <= ((prim_flag & ~prim_wmask) | (prim_flag_wd & prim_wmask)) | prim_set;
         grp_flag  <= ((grp_flag & ~grp_wmask) | (grp_flag_wd & grp_wmask)) | grp_set;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prim_en <= '0;
         grp_en  <= '0;
      end else begin
         prim_en <= (prim_en & ~prim_wmask) | (prim_en_wd & prim_wmask);
         grp_en  <= (grp_en & ~grp_wmask) | (grp_en_wd & grp_wmask);
      end
   end

   // service entry clears the global enable; software may set it again
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         global_irq_enable <= 1'b0;
      end else if (wr_prim_a) begin
         global_irq_enable <= wd[0];
      end else if (irq_ack) begin
         global_irq_enable <= 1'b0;
      end
   end

   // monitor enable, bandgap force and trip level
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         supply_monitor_on <= REG_RESET[MON_ON_BIT];
         bandgap_force_on  <= REG_RESET[MON_BG_BIT];
         trip_level_select <= REG_RESET[MON_LEVEL_LSB +: LEVEL_W];
      end else if (reg_req.wr && (reg_req.addr == IDX_MONITOR)) begin
         supply_monitor_on <= wd[MON_ON_BIT];
         bandgap_force_on  <= wd[MON_BG_BIT];
         trip_level_select <= wd[MON_LEVEL_LSB +: LEVEL_W];
      end
   end

   // two bits per pin, upper nibble not stored
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         edge_select <= REG_RESET[3:0];
      end else if (reg_req.wr && (reg_req.addr == IDX_EDGE)) begin
         edge_select <= wd[3:0];
      end
   end

   // only enabled flags make a vector; the global enable gates the request only
   assign pending = prim_flag & prim_en;

   // fixed priority, vector re-evaluated every cycle regardless of acknowledge
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_vector <= '0;
      end else begin
         irq_vector <= first_set(pending);
      end
   end

   // request only under global enable; drop on acknowledge
   // so the core cannot enter the same service twice
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_req <= 1'b0;
      end else begin
         irq_req <= global_irq_enable && (|pending) && !irq_ack;
      end
   end

   // a flag rising from zero wakes; a preset flag does not
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wake <= 1'b0;
      end else begin
         wake <= (|(prim_set & ~prim_flag)) || (|(grp_set & ~grp_flag));
      end
   end

   always_comb begin
      next_rdata = '0;
      unique case (reg_req.addr)
         IDX_MONITOR: begin
            next_rdata[MON_FLAG_BIT]                = low_supply_flag;
            next_rdata[MON_ON_BIT]                  = supply_monitor_on;
            next_rdata[MON_BG_BIT]                  = bandgap_force_on;
            next_rdata[MON_LEVEL_LSB +: LEVEL_W]    = trip_level_select;
         end
         IDX_EDGE: begin
            next_rdata[3:0] = edge_select;
         end
         IDX_PRIM_A: begin
            next_rdata = {1'b0, prim_flag[2:0], prim_en[2:0], global_irq_enable};
         end
         IDX_PRIM_B: begin
            next_rdata = {prim_flag[6:3], prim_en[6:3]};
         end
         IDX_PRIM_C: begin
            next_rdata = {3'b000, prim_flag[7], 3'b000, prim_en[7]};
         end
         IDX_GROUP_A, IDX_GROUP_B, IDX_GROUP_C: begin
            for (int g = 0; g < GROUPS; g++) begin
               if (grp_hit(reg_req.addr, g)) begin
                  next_rdata = {grp_flag[g*4 +: 4], grp_en[g*4 +: 4]};
               end
            end
         end
      endcase
   end

   // held in a flop so the core reads one settled snapshot
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= '0;
      end else if (reg_req.rd) begin
         reg_rdata <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// ### dv/irq_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module irq_core_model (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       irq_req,
   input  wire logic [2:0] irq_vector,
   input  wire logic [3:0] ack_delay,
   output logic            irq_ack,
   output logic [2:0]      taken_vector
);
   logic [3:0] wait_cnt;
   logic       in_service;
   // one entry per request; slow cores stall by ack_delay
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_ack <= 1'b0;
         in_service <= 1'b0;
         wait_cnt <= 4'h0;
         taken_vector <= 3'h0;
      end else begin
         irq_ack <= 1'b0;
         if (!irq_req) begin
            in_service <= 1'b0;
            wait_cnt <= 4'h0;
         end else if (!in_service && wait_cnt >= ack_delay) begin
            irq_ack <= 1'b1;
            in_service <= 1'b1;
            taken_vector <= irq_vector;
         end else if (!in_service) begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ### dv/low_voltage_irq_props.sv
`timescale 1ns/1ns
`default_nettype none
module low_voltage_irq_props #(
   parameter int FLAG_TO_IRQ_CYC = 10
) (
   input wire logic                             ref_clk,
   input wire logic                             reset_n,
   input wire low_voltage_irq_pkg::reg_req_s    reg_req,
   input wire logic [7:0]                       reg_rdata,
   input wire low_voltage_irq_pkg::power_mode_e power_mode,
   input wire logic                             low_supply_reset,
   input wire logic [7:0]                       below_trip,
   input wire logic [2:0]                       trip_level_select,
   input wire logic                             monitor_power,
   input wire logic                             bandgap_on,
   input wire logic                             ext_irq_pin_a,
   input wire logic                             ext_irq_pin_b,
   input wire low_voltage_irq_pkg::irq_sources_s sources,
   input wire logic                             irq_ack,
   input wire logic                             irq_req,
   input wire logic [2:0]                       irq_vector,
   input wire logic                             wake
);
   import low_voltage_irq_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sleep_off_a: assert property (power_mode == MODE_SLEEP |-> !monitor_power)
      else $error("monitor powered in sleep");
   bandgap_src_a: assert property ((monitor_power || low_supply_reset) |-> bandgap_on)
      else $error("bandgap off while needed");
   trip_wr_a: assert property (reg_req.wr && reg_req.addr == IDX_MONITOR
      |=> trip_level_select == $past(reg_req.wdata[2:0])) else $error("trip level not taken");
   mon_rsv_a: assert property (reg_req.rd && reg_req.addr == IDX_MONITOR
      |=> reg_rdata[7:6] == 2'h0) else $error("monitor reserved bits set");
   edge_rsv_a: assert property (reg_req.rd && reg_req.addr == IDX_EDGE
      |=> reg_rdata[7:4] == 4'h0) else $error("edge reserved bits set");
   prim_rsv_a: assert property (reg_req.rd && reg_req.addr == IDX_PRIM_C
      |=> (reg_rdata & 8'hEE) == 8'h00) else $error("primary c reserved bits set");
   group_rsv_a: assert property (reg_req.rd && reg_req.addr == IDX_GROUP_C
      |=> (reg_rdata & 8'hCC) == 8'h00) else $error("group c reserved bits set");
   ack_drop_a: assert property (irq_ack && !(reg_req.wr && reg_req.addr == IDX_PRIM_A)
      |-> ##[1:2] !irq_req) else $error("request stays after service entry");
   gie_off_a: assert property (reg_req.wr && reg_req.addr == IDX_PRIM_A && !reg_req.wdata[0]
      |-> ##[1:2] !irq_req) else $error("request without global enable");
   cover property (irq_ack);
   cover property (wake);
   cover property (irq_req && irq_vector == 3'h5);
endmodule
`default_nettype wire

// ### dv/tb_low_voltage_irq_control.sv
`timescale 1ns/1ns
`default_nettype none
module tb_low_voltage_irq_control;
   import low_voltage_irq_pkg::*;
   localparam int CYC = 3;
   logic ref_clk = 1'b0;
   logic reset_n, low_supply_reset, monitor_power, bandgap_on;
   logic ext_irq_pin_a, ext_irq_pin_b, irq_ack, irq_req, wake;
   logic [7:0] reg_rdata, below_trip;
   logic [2:0] trip_level_select, irq_vector, taken_vector;
   logic [3:0] ack_delay;
   reg_req_s reg_req;
   power_mode_e power_mode;
   irq_sources_s sources;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_wake = 0;
   low_voltage_irq_control #(.FLAG_TO_IRQ_CYC(CYC)) dut_u (.ref_clk, .reset_n, .reg_req,
      .reg_rdata, .power_mode, .low_supply_reset, .below_trip, .trip_level_select,
      .monitor_power, .bandgap_on, .ext_irq_pin_a, .ext_irq_pin_b, .sources, .irq_ack,
      .irq_req, .irq_vector, .wake);
   irq_core_model core_u (.ref_clk, .reset_n, .irq_req, .irq_vector, .ack_delay, .irq_ack,
      .taken_vector);
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (wake === 1'b1) n_wake <= n_wake + 1;
   task automatic report_and_stop();
      if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_req.wr = 1'b1; reg_req.addr = a; reg_req.wdata = d;
      @(negedge ref_clk); reg_req.wr = 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic rc(input logic [2:0] a, input logic [7:0] e, input string w);
      reg_req.rd = 1'b1; reg_req.addr = a;
      @(negedge ref_clk); reg_req.rd = 1'b0;
      @(negedge ref_clk); chk(w, e, reg_rdata);
   endtask
   task automatic wait_ack(input logic [2:0] v);
      for (int n = 0; n < 30 && irq_ack !== 1'b1; n++) @(negedge ref_clk);
      chk("ack seen", 8'h01, {7'h0, irq_ack});
      chk("vector", {5'h0, v}, {5'h0, taken_vector});
      // let service entry reach the global enable before anything else
      @(negedge ref_clk);
   endtask
   task automatic t_access();
      logic [7:0] exp [8] = '{8'h1F, 8'h0F, 8'h7E, 8'hFF, 8'h11, 8'hFF, 8'hFF, 8'h33};
      for (int i = 0; i < 8; i++) rc(3'(i), REG_RESET, "reset value");
      for (int i = 0; i < 8; i++) wr(3'(i), (i == 2) ? 8'hFE : 8'hFF);
      for (int i = 0; i < 8; i++) rc(3'(i), exp[i], "writable bits");
      for (int m = 0; m < 4; m++) begin
         power_mode = power_mode_e'(m); @(negedge ref_clk);
         chk("monitor power", 8'(m != 3), {7'h0, monitor_power});
      end
      power_mode = MODE_FAST;
      wr(IDX_MONITOR, 8'h08); chk("bandgap forced", 8'h01, {7'h0, bandgap_on});
      wr(IDX_MONITOR, 8'h00); chk("bandgap idle", 8'h00, {7'h0, bandgap_on});
      low_supply_reset = 1'b1; @(negedge ref_clk);
      chk("bandgap reset", 8'h01, {7'h0, bandgap_on});
      low_supply_reset = 1'b0;
      // groups first so shared flags are not re-set behind us
      for (int i = 7; i >= 0; i--) wr(3'(i), 8'h00);
   endtask
   task automatic t_trip();
      for (int n = 0; n < 8; n++) begin
         wr(IDX_MONITOR, 8'(8'h10 | n));
         chk("trip select", 8'(n), {5'h0, trip_level_select});
         below_trip = 8'(8'hFF << n);
         // settle before trusting the flag
         repeat (6) @(negedge ref_clk);
         rc(IDX_MONITOR, 8'(8'h30 | n), "flag below");
         below_trip = 8'(8'hFE << n);
         repeat (6) @(negedge ref_clk);
         rc(IDX_MONITOR, 8'(8'h10 | n), "flag above");
      end
      // supply hovering at the level: the flag may chatter, its final state counts
      repeat (4) begin
         below_trip = 8'h80;
         @(negedge ref_clk);
         below_trip = 8'h00;
         @(negedge ref_clk);
      end
      below_trip = 8'h80;
      repeat (6) @(negedge ref_clk);
      rc(IDX_MONITOR, 8'h37, "flag after hover");
      below_trip = 8'hFF; power_mode = MODE_SLEEP;
      repeat (6) @(negedge ref_clk);
      rc(IDX_MONITOR, 8'h17, "flag in sleep");
      power_mode = MODE_FAST; below_trip = 8'h00;
      wr(IDX_MONITOR, 8'h00); wr(IDX_GROUP_B, 8'h00);
   endtask
   task automatic t_low_irq();
      int n = 0;
      int w;
      ack_delay = 4'h3;
      wr(IDX_GROUP_B, 8'h08); wr(IDX_PRIM_B, 8'h08); wr(IDX_MONITOR, 8'h10);
      repeat (6) @(negedge ref_clk);
      wr(IDX_PRIM_A, 8'h01); w = n_wake; below_trip = 8'hFF;
      while (irq_req !== 1'b1 && n < 40) begin @(negedge ref_clk); n++; end
      chk("delay window", 8'(5 + CYC), 8'(n));
      chk("wake on low", 8'(n_wake > w), 8'h01);
      wait_ack(3'h6);
      rc(IDX_PRIM_A, 8'h00, "enable after entry");
      wr(IDX_GROUP_B, 8'h00); wr(IDX_PRIM_B, 8'h00); below_trip = 8'h00;
      repeat (6) @(negedge ref_clk);
      // preset flag so a new low supply cannot wake
      wr(IDX_GROUP_B, 8'h80); w = n_wake; below_trip = 8'hFF;
      repeat (20) @(negedge ref_clk);
      chk("no wake preset", 8'(n_wake), 8'(w));
      below_trip = 8'h00; wr(IDX_MONITOR, 8'h00); wr(IDX_GROUP_B, 8'h00);
   endtask
   task automatic t_sources();
      sources = '1;
      @(negedge ref_clk);
      sources = '0;
      @(negedge ref_clk);
      rc(IDX_PRIM_A, 8'h40, "auto conv flag");
      rc(IDX_PRIM_B, 8'h30, "time base flags");
      rc(IDX_PRIM_C, 8'h00, "group flag gated");
      rc(IDX_GROUP_A, 8'hF0, "timer flags");
      rc(IDX_GROUP_B, 8'h70, "grouped flags");
      rc(IDX_GROUP_C, 8'h30, "compact timer flags");
      for (int i = 7; i >= 2; i--) wr(3'(i), 8'h00);
   endtask
   task automatic t_edges();
      logic [7:0] f;
      for (int p = 0; p < 2; p++) for (int m = 0; m < 4; m++) begin
         f = p ? 8'h20 : 8'h10;
         wr(IDX_EDGE, 8'(m << (2 * p)));
         if (p) ext_irq_pin_b = 1'b1; else ext_irq_pin_a = 1'b1;
         repeat (5) @(negedge ref_clk);
         rc(IDX_PRIM_A, m[0] ? f : 8'h00, "rise edge");
         wr(IDX_PRIM_A, 8'h00);
         if (p) ext_irq_pin_b = 1'b0; else ext_irq_pin_a = 1'b0;
         repeat (5) @(negedge ref_clk);
         rc(IDX_PRIM_A, m[1] ? f : 8'h00, "fall edge");
         wr(IDX_PRIM_A, 8'h00);
      end
      wr(IDX_EDGE, 8'h00);
   endtask
   task automatic t_priority();
      ack_delay = 4'h0;
      wr(IDX_GROUP_A, 8'h01); wr(IDX_PRIM_B, 8'h05); wr(IDX_PRIM_A, 8'h08);
      sources.auto_conv = 1'b1; sources.timebase[0] = 1'b1; sources.timer_std[0] = 1'b1;
      @(negedge ref_clk); sources = '0;
      repeat (6) @(negedge ref_clk);
      chk("gated request", 8'h00, {7'h0, irq_req});
      rc(IDX_PRIM_A, 8'h48, "flag held");
      wr(IDX_PRIM_A, 8'h49); wait_ack(3'h2);
      wr(IDX_PRIM_A, 8'h09); wait_ack(3'h3);
      wr(IDX_PRIM_B, 8'h05);
      wr(IDX_PRIM_A, 8'h09); wait_ack(3'h5);
      wr(IDX_GROUP_A, 8'h00); wr(IDX_PRIM_B, 8'h00); wr(IDX_PRIM_A, 8'h00);
   endtask
   initial begin
      reg_req = '0; power_mode = MODE_FAST; low_supply_reset = 1'b0; below_trip = 8'h00;
      ext_irq_pin_a = 1'b0; ext_irq_pin_b = 1'b0; sources = '0; ack_delay = 4'h0;
      reset_n = 1'b0;
      repeat (5) @(negedge ref_clk);
      reset_n = 1'b1;
      @(negedge ref_clk);
      t_access();
      t_sources();
      t_trip();
      t_low_irq();
      t_edges();
      t_priority();
      report_and_stop();
   end
   // tests take about 550 cycles
   initial begin
      #100000;
      n_mismatch++;
      report_and_stop();
   end
endmodule
bind low_voltage_irq_control low_voltage_irq_props #(.FLAG_TO_IRQ_CYC(FLAG_TO_IRQ_CYC)) props_u (
   .ref_clk, .reset_n, .reg_req, .reg_rdata, .power_mode, .low_supply_reset, .below_trip,
   .trip_level_select, .monitor_power, .bandgap_on, .ext_irq_pin_a, .ext_irq_pin_b,
   .sources, .irq_ack, .irq_req, .irq_vector, .wake);
`default_nettype wire

// ### inc/low_voltage_irq_pkg.sv
package low_voltage_irq_pkg;
   localparam int REG_ADDR_W = 3;
   localparam int DATA_W     = 8;
   // register indices in the special register space
   localparam logic [2:0] IDX_MONITOR = 3'h0;
   localparam logic [2:0] IDX_EDGE    = 3'h1;
   localparam logic [2:0] IDX_PRIM_A  = 3'h2;
   localparam logic [2:0] IDX_PRIM_B  = 3'h3;
   localparam logic [2:0] IDX_PRIM_C  = 3'h4;
   localparam logic [2:0] IDX_GROUP_A = 3'h5;
   localparam logic [2:0] IDX_GROUP_B = 3'h6;
   localparam logic [2:0] IDX_GROUP_C = 3'h7;
   localparam logic [7:0] REG_RESET   = 8'h00;
   // monitor control fields
   localparam int MON_FLAG_BIT  = 5;
   localparam int MON_ON_BIT    = 4;
   localparam int MON_BG_BIT    = 3;
   localparam int MON_LEVEL_LSB = 0;
   localparam int LEVEL_W       = 3;
   localparam int LEVELS        = 8;
   // edge select fields
   localparam int EDGE_PIN_B_LSB = 2;
   localparam int EDGE_PIN_A_LSB = 0;
   // group registers: flags high nibble, enables low nibble
   localparam int GROUP_FLAG_LSB = 4;
   localparam int GROUP_EN_LSB   = 0;
   localparam int GROUPS         = 3;
   localparam logic [11:0] GROUP_MASK = 12'h3FF;
   // primary source index, lowest index wins
   localparam int PRIMARY = 8;
   localparam int VEC_W   = 3;
   // timing
   localparam int CLK_PERIOD_NS        = 10;
   localparam int FLAG_TO_IRQ_DELAY_NS = 100;
   localparam int FLAG_TO_IRQ_CYCLES   =
      (FLAG_TO_IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      EDGE_OFF  = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } edge_mode_e;

   typedef enum logic [1:0] {
      MODE_FAST  = 2'h0,
      MODE_SLOW  = 2'h1,
      MODE_IDLE  = 2'h2,
      MODE_SLEEP = 2'h3
   } power_mode_e;

   // 2.0 2.2 2.4 2.7 3.0 3.3 3.6 4.0 volts
   typedef enum logic [2:0] {
      TRIP_2V0 = 3'h0, TRIP_2V2 = 3'h1, TRIP_2V4 = 3'h2, TRIP_2V7 = 3'h3,
      TRIP_3V0 = 3'h4, TRIP_3V3 = 3'h5, TRIP_3V6 = 3'h6, TRIP_4V0 = 3'h7
   } trip_level_e;

   typedef struct packed {
      logic [3:0] timer_std;   // 1 match a, 1 match p, 0 match a, 0 match p
      logic       eeprom;
      logic       serial;
      logic       adc;
      logic [1:0] timer_cpt;   // match a, match p
      logic [1:0] timebase;
      logic       auto_conv;
   } irq_sources_s;

   typedef struct packed {
      logic                  wr;
      logic                  rd;
      logic [REG_ADDR_W-1:0] addr;
      logic [DATA_W-1:0]     wdata;
   } reg_req_s;
endpackage
